// File: logic/pll_clk_ctrl.sv
// pll reference pin select, pll p/j/d factors and clock resync control
`timescale 1ns/1ns
`include "pll_clk_regs.svh"

// Operation
// - ref pin code 011 takes pin 0, 101 takes pin 2; others mute the reference
// - auto resync enable bit, reset 1, turns automatic resync on or off
// - with auto on, resync runs just before dac leaves standby
// - writing request bit 1 halts dac, charge pump and oversampling clocks
// - request bit back to 0 restarts clocks at next frame start; resets 0
// - pre-divider p equals field plus one, codes 0 to 14
// - multiplier j equals its six-bit binary value, 1 to 63
// - in auto set mode programmed p and j are ignored
// - fractional d is a 14-bit field 0 to 9999, ignored in auto set
module pll_clk_ctrl
    import pll_clk_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic CLK_EN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic GENERAL_PIN_0_I,
    input wire logic GENERAL_PIN_2_I,
    input wire logic FRAME_START_I,
    input wire logic DAC_WAKE_I,
    input wire logic AUTO_SET_I,
    input wire logic [3:0] AUTO_P_I,
    input wire logic [5:0] AUTO_J_I,
    input wire logic [13:0] AUTO_D_I,
    output logic [7:0] RDATA_O,
    output logic PLL_REF_CLK_O,
    output logic REF_MUTE_O,
    output logic CLK_HALT_O,
    output logic DAC_RUN_O,
    output logic [4:0] PLL_P_O,
    output logic [5:0] PLL_J_O,
    output logic [13:0] PLL_D_O
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic ref_code_ok(input logic [2:0] code);
        ref_code_ok = (code == `REF_PIN0_CODE) || (code == `REF_PIN2_CODE);
    endfunction : ref_code_ok

    function automatic logic [4:0] p_factor(input logic [3:0] code);
        p_factor = {1'b0, code} + 5'h1;
    endfunction : p_factor

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ref_pin_reg;
    logic [7:0] resync_reg;
    logic [7:0] resync_next;
    logic [7:0] prediv_reg;
    logic [7:0] mult_reg;
    logic [7:0] frac_hi_reg;
    logic [7:0] frac_lo_reg;
    logic wr_resync;
    logic req_next;
    logic auto_en;
    logic [2:0] pll_ref_pin_sel;
    logic [3:0] pll_prediv_p;
    logic [5:0] pll_mult_j;
    logic [13:0] pll_frac_d;
    resync_state_t state_reg;
    resync_state_t state_next;
    logic wake_sync_reg;

    assign wr_resync = WR_I && hit(ADDR_I, `OFS_RESYNC);
    assign resync_next = wr_resync ? WDATA_I : resync_reg;
    assign req_next = resync_next[`REQ_BIT];
    assign auto_en = resync_reg[`AUTO_EN_BIT];
    assign pll_ref_pin_sel = ref_pin_reg[`REF_SEL_MSB:0];
    assign pll_prediv_p = prediv_reg[`PREDIV_MSB:`PREDIV_LSB];
    assign pll_mult_j = mult_reg[`MULT_MSB:0];
    assign pll_frac_d = {frac_hi_reg[`FRAC_HI_MSB:0], frac_lo_reg};

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ref_pin_reg <= `RST_REF_PIN;
            resync_reg <= `RST_RESYNC;
            prediv_reg <= `RST_PREDIV;
            mult_reg <= `RST_INT_MULT;
            frac_hi_reg <= `RST_FRAC;
            frac_lo_reg <= `RST_FRAC;
        end else if (CLK_EN_I && WR_I) begin
            if (hit(ADDR_I, `OFS_REF_PIN)) begin
                ref_pin_reg <= WDATA_I;
            end
            if (wr_resync) begin
                resync_reg <= WDATA_I;
            end
            if (hit(ADDR_I, `OFS_PREDIV)) begin
                prediv_reg <= WDATA_I;
            end
            if (hit(ADDR_I, `OFS_INT_MULT)) begin
                mult_reg <= WDATA_I;
            end
            if (hit(ADDR_I, `OFS_FRAC_HI)) begin
                frac_hi_reg <= WDATA_I;
            end
            if (hit(ADDR_I, `OFS_FRAC_LO)) begin
                frac_lo_reg <= WDATA_I;
            end
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        unique case (ADDR_I)
            `OFS_REF_PIN: rdata_next = ref_pin_reg;
            `OFS_RESYNC: rdata_next = resync_reg;
            `OFS_PREDIV: rdata_next = prediv_reg;
            `OFS_INT_MULT: rdata_next = mult_reg;
            `OFS_FRAC_HI: rdata_next = frac_hi_reg;
            `OFS_FRAC_LO: rdata_next = frac_lo_reg;
            `OFS_STATUS: begin
                rdata_next[`STAT_HALT_BIT] = CLK_HALT_O;
                rdata_next[`STAT_MUTE_BIT] = REF_MUTE_O;
                rdata_next[`STAT_RUN_BIT] = DAC_RUN_O;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RDATA_O <= 8'h00;
        end else if (CLK_EN_I) begin
            RDATA_O <= RD_I ? rdata_next : 8'h00;
        end
    end

    chk_status_halt:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && RD_I && ADDR_I == `OFS_STATUS)
        |=> RDATA_O[`STAT_HALT_BIT] == $past(CLK_HALT_O))
    else $error("status halt bit differs from halt output");

    chk_read_idle_zero:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && !RD_I) |=> RDATA_O == 8'h00)
    else $error("read data not cleared after its cycle");

    // ----------------------------------------------------------------
    // pll reference pin
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PLL_REF_CLK_O <= 1'b0;
            REF_MUTE_O <= 1'b1;
        end else if (CLK_EN_I) begin
            REF_MUTE_O <= !ref_code_ok(pll_ref_pin_sel);
            if (pll_ref_pin_sel == `REF_PIN0_CODE) begin
                PLL_REF_CLK_O <= GENERAL_PIN_0_I;
            end else if (pll_ref_pin_sel == `REF_PIN2_CODE) begin
                PLL_REF_CLK_O <= GENERAL_PIN_2_I;
            end else begin
                PLL_REF_CLK_O <= 1'b0;
            end
        end
    end

    chk_ref_pin_zero:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && pll_ref_pin_sel == `REF_PIN0_CODE)
        |=> (PLL_REF_CLK_O == $past(GENERAL_PIN_0_I)) && !REF_MUTE_O)
    else $error("pin 0 not routed to pll reference");

    chk_ref_mute_code:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && !ref_code_ok(pll_ref_pin_sel))
        |=> REF_MUTE_O && !PLL_REF_CLK_O)
    else $error("unusable reference code not muted");

    chk_pin_two_route:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && pll_ref_pin_sel == `REF_PIN2_CODE)
        |=> (PLL_REF_CLK_O == $past(GENERAL_PIN_2_I)) && !REF_MUTE_O)
    else $error("pin 2 not routed to pll reference");

    // ----------------------------------------------------------------
    // pll factors
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PLL_P_O <= 5'h1;
            PLL_J_O <= 6'h00;
            PLL_D_O <= 14'h0000;
        end else if (CLK_EN_I) begin
            if (AUTO_SET_I) begin
                PLL_P_O <= p_factor(AUTO_P_I);
                PLL_J_O <= AUTO_J_I;
                PLL_D_O <= AUTO_D_I;
            end else begin
                PLL_P_O <= p_factor(pll_prediv_p);
                PLL_J_O <= pll_mult_j;
                PLL_D_O <= pll_frac_d;
            end
        end
    end

    chk_prediv_plus_one:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && !AUTO_SET_I)
        |=> PLL_P_O == {1'b0, $past(pll_prediv_p)} + 5'h1)
    else $error("pre-divider p is not field plus one");

    chk_mult_direct:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && !AUTO_SET_I) |=> PLL_J_O == $past(pll_mult_j))
    else $error("multiplier j differs from field");

    chk_auto_set_ignore:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && AUTO_SET_I)
        |=> PLL_J_O == $past(AUTO_J_I)
            && PLL_P_O == {1'b0, $past(AUTO_P_I)} + 5'h1)
    else $error("programmed factors used in auto set mode");

    chk_frac_field:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && !AUTO_SET_I) |=> PLL_D_O == $past(pll_frac_d))
    else $error("fractional d differs from field");

    chk_enable_freeze:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (!CLK_EN_I)
        |=> $stable(PLL_P_O) && $stable(PLL_J_O) && $stable(mult_reg) && $stable(state_reg))
    else $error("state moved while clock enable low");

    // ----------------------------------------------------------------
    // resync sequencer
    // ----------------------------------------------------------------
    logic auto_start;
    logic align_done;

    assign auto_start = auto_en && DAC_WAKE_I && !DAC_RUN_O && !wake_sync_reg;
    assign align_done = FRAME_START_I && !req_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (req_next) begin
                    state_next = ST_HALT;
                end else if (auto_start) begin
                    state_next = ST_AUTO;
                end
            end
            ST_HALT: begin
                if (!req_next) begin
                    state_next = ST_ALIGN;
                end
            end
            ST_AUTO: begin
                state_next = req_next ? ST_HALT : ST_ALIGN;
            end
            ST_ALIGN: begin
                if (req_next) begin
                    state_next = ST_HALT;
                end else if (FRAME_START_I) begin
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_reg <= ST_RUN;
            CLK_HALT_O <= 1'b0;
        end else if (CLK_EN_I) begin
            state_reg <= state_next;
            CLK_HALT_O <= (state_next != ST_RUN);
        end
    end

    // dac wake waits for the auto resync to close
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wake_sync_reg <= 1'b0;
            DAC_RUN_O <= 1'b0;
        end else if (CLK_EN_I) begin
            if (!DAC_WAKE_I) begin
                wake_sync_reg <= 1'b0;
                DAC_RUN_O <= 1'b0;
            end else if (!auto_en && !DAC_RUN_O) begin
                DAC_RUN_O <= 1'b1;
            end else if (state_reg == ST_RUN && auto_start && !req_next) begin
                wake_sync_reg <= 1'b1;
            end else if (wake_sync_reg && state_reg == ST_ALIGN && align_done) begin
                wake_sync_reg <= 1'b0;
                DAC_RUN_O <= 1'b1;
            end
        end
    end

    chk_no_auto_wake:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && !auto_en && DAC_WAKE_I && !DAC_RUN_O)
        |=> DAC_RUN_O)
    else $error("wake delayed with auto resync off");

    chk_auto_before_run:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && state_reg == ST_RUN && auto_start && !req_next)
        |=> CLK_HALT_O && !DAC_RUN_O)
    else $error("dac left standby without resync");

    chk_wake_wait_frame:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && auto_en && DAC_WAKE_I && !DAC_RUN_O && state_reg != ST_ALIGN)
        |=> !DAC_RUN_O)
    else $error("dac entered normal operation off a resync");

    chk_request_halts:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && wr_resync && WDATA_I[`REQ_BIT]) |=> CLK_HALT_O)
    else $error("request did not halt clocks");

    chk_frame_resume:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && state_reg == ST_ALIGN && align_done)
        |=> !CLK_HALT_O && state_reg == ST_RUN)
    else $error("clocks not resumed at frame start");

    chk_hold_to_frame:
    assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (CLK_EN_I && state_reg == ST_ALIGN && !FRAME_START_I)
        |=> CLK_HALT_O)
    else $error("clocks resumed off frame boundary");

endmodule : pll_clk_ctrl

// File: logic/pll_clk_pkg.sv
// types shared by the pll/resync block
package pll_clk_pkg;

    // gray along run -> halt -> align; align -> run flips both bits
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_HALT = 2'h1,
        ST_ALIGN = 2'h3,
        ST_AUTO = 2'h2
    } resync_state_t;

endpackage : pll_clk_pkg

// File: logic/pll_clk_regs.svh
// register offsets, field positions, reset values for the pll/resync block
`ifndef PLL_CLK_REGS_SVH
`define PLL_CLK_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define OFS_REF_PIN 8'h12
`define OFS_RESYNC 8'h13
`define OFS_PREDIV 8'h14
`define OFS_INT_MULT 8'h15
`define OFS_FRAC_HI 8'h16
`define OFS_FRAC_LO 8'h17
`define OFS_STATUS 8'h1f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_REF_PIN 8'h00
`define RST_RESYNC 8'h10
`define RST_PREDIV 8'h01
`define RST_INT_MULT 8'h00
`define RST_FRAC 8'h00

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define REF_SEL_MSB 2
`define AUTO_EN_BIT 4
`define REQ_BIT 0
`define PREDIV_MSB 6
`define PREDIV_LSB 3
`define MULT_MSB 5
`define FRAC_HI_MSB 5
`define REF_PIN0_CODE 3'h3
`define REF_PIN2_CODE 3'h5
`define STAT_HALT_BIT 0
`define STAT_MUTE_BIT 1
`define STAT_RUN_BIT 2

`endif

// File: tb/pll_divider_and_clock_resync_test.sv
// self-checking bench for the pll/resync block
`timescale 1ns/1ns
module pll_divider_and_clock_resync_test;
    logic clock, reset, clk_en, pin0, pin2, frame_start, dac_wake, auto_set;
    logic [3:0] auto_p, p;
    logic [5:0] auto_j, j;
    logic [13:0] auto_d, d;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, ref_clk, ref_mute, clk_halt, dac_run;
    logic [4:0] pll_p;
    logic [5:0] pll_j;
    logic [13:0] pll_d;
    integer err_count = 0;
    integer checked = 0;
    integer seed = 86;

    pll_clk_ctrl pll_clk_ctrl_i (.CLOCK_I(clock), .RESET_I(reset), .CLK_EN_I(clk_en),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .GENERAL_PIN_0_I(pin0),
        .GENERAL_PIN_2_I(pin2), .FRAME_START_I(frame_start), .DAC_WAKE_I(dac_wake),
        .AUTO_SET_I(auto_set), .AUTO_P_I(auto_p), .AUTO_J_I(auto_j), .AUTO_D_I(auto_d),
        .RDATA_O(rdata), .PLL_REF_CLK_O(ref_clk), .REF_MUTE_O(ref_mute),
        .CLK_HALT_O(clk_halt), .DAC_RUN_O(dac_run), .PLL_P_O(pll_p), .PLL_J_O(pll_j),
        .PLL_D_O(pll_d));
    pll_host_model pll_host_model_i (.clock_i(clock), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // expectations, compares and helpers
    // ----------------------------------------------------------------
    function automatic logic exp_ref(input logic [2:0] c, input logic a, input logic b);
        return (c == 3'h3) ? a : (c == 3'h5) ? b : 1'b0;
    endfunction : exp_ref

    function automatic logic [4:0] exp_p(input logic [3:0] c);
        return {1'b0, c} + 5'h01;
    endfunction : exp_p

    task automatic cmp_out(input string n, input logic [13:0] e, input logic [13:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_out

    task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        pll_host_model_i.read_reg(a, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED register %h expected %h seen %h", a, e, g);
        end
    endtask : cmp_reg

    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : ticks

    task automatic pulse_frame;
        @(posedge clock) frame_start <= 1'b1;
        @(posedge clock) frame_start <= 1'b0;
    endtask : pulse_frame

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        finish_test;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {reset, clk_en} = 2'b11;
        {pin0, pin2, frame_start, dac_wake, auto_set} = 5'h00;
        {auto_p, auto_j, auto_d} = 24'h000000;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        cmp_reg(8'h12, 8'h00);
        cmp_reg(8'h13, 8'h10);
        cmp_reg(8'h14, 8'h01);
        cmp_reg(8'h15, 8'h00);
        cmp_reg(8'h20, 8'h00);
        for (int c = 0; c < 8; c++) begin
            @(posedge clock);
            pin0 <= 1'($random(seed));
            pin2 <= 1'($random(seed));
            pll_host_model_i.write_reg(8'h12, {5'h00, c[2:0]});
            ticks(2);
            cmp_out("ref mute", {13'h0, !(c == 3 || c == 5)}, {13'h0, ref_mute});
            cmp_out("ref clock", {13'h0, exp_ref(c[2:0], pin0, pin2)}, {13'h0, ref_clk});
        end
        for (int i = 0; i < 12; i++) begin
            p = (i == 1) ? 4'he : 4'($unsigned($random(seed)) % 15);
            j = (i == 0) ? 6'h01 : (i == 1) ? 6'h3f : 6'(1 + $unsigned($random(seed)) % 63);
            d = (i == 1) ? 14'h270f : 14'($unsigned($random(seed)) % 10000);
            pll_host_model_i.write_reg(8'h14, {1'b0, p, 3'h1});
            pll_host_model_i.write_reg(8'h15, {2'h0, j});
            pll_host_model_i.write_reg(8'h16, {2'h0, d[13:8]});
            pll_host_model_i.write_reg(8'h17, d[7:0]);
            ticks(2);
            cmp_out("p factor", 14'(exp_p(p)), 14'(pll_p));
            cmp_out("j factor", 14'(j), 14'(pll_j));
            cmp_out("d factor", d, pll_d);
            @(posedge clock);
            auto_set <= 1'b1;
            auto_p <= 4'($random(seed));
            auto_j <= 6'($random(seed));
            auto_d <= 14'($random(seed));
            ticks(2);
            cmp_out("auto p", 14'(exp_p(auto_p)), 14'(pll_p));
            cmp_out("auto j", 14'(auto_j), 14'(pll_j));
            cmp_out("auto d", auto_d, pll_d);
            @(posedge clock) auto_set <= 1'b0;
        end
        @(posedge clock) clk_en <= 1'b0;
        pll_host_model_i.write_reg(8'h15, 8'h2a);
        @(posedge clock) clk_en <= 1'b1;
        cmp_reg(8'h15, {2'h0, j});
        pll_host_model_i.write_reg(8'h13, 8'h11);
        ticks(1);
        cmp_out("halt on request", 14'h1, 14'(clk_halt));
        cmp_reg(8'h1f, 8'h03);
        pulse_frame;
        ticks(2);
        cmp_out("halt while requested", 14'h1, 14'(clk_halt));
        pll_host_model_i.write_reg(8'h13, 8'h10);
        ticks(2);
        cmp_out("halt until frame", 14'h1, 14'(clk_halt));
        pulse_frame;
        ticks(1);
        cmp_out("resume at frame", 14'h0, 14'(clk_halt));
        @(posedge clock) dac_wake <= 1'b1;
        ticks(1);
        cmp_out("auto halt", 14'h1, 14'(clk_halt));
        cmp_out("run held", 14'h0, 14'(dac_run));
        pulse_frame;
        ticks(1);
        cmp_out("run after frame", 14'h1, 14'(dac_run));
        cmp_out("auto resume", 14'h0, 14'(clk_halt));
        cmp_reg(8'h1f, 8'h06);
        @(posedge clock) dac_wake <= 1'b0;
        pll_host_model_i.write_reg(8'h13, 8'h00);
        @(posedge clock) dac_wake <= 1'b1;
        ticks(2);
        cmp_out("run without resync", 14'h1, 14'(dac_run));
        cmp_out("no halt without resync", 14'h0, 14'(clk_halt));
        finish_test;
    end
endmodule : pll_divider_and_clock_resync_test

// File: tb/pll_host_model.sv
// host model driving the register port of the pll/resync block
`timescale 1ns/1ns
`include "pll_clk_regs.svh"
module pll_host_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == `OFS_PREDIV && v[6:3] == 4'hf) v[6:3] = 4'he;
        if (a == `OFS_INT_MULT && v[5:0] == 6'h00) v[5:0] = 6'h01;
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        @(negedge clock_i);
        d = rdata_i;
    endtask : read_reg
endmodule : pll_host_model
